// ---- design/usb_cfg_pkg.sv ----
// Package: register map, field positions, reset values and timing for the USB config block
package usb_cfg_pkg;
	// Byte addresses on the APB (printed offsets moved to multiples of four where needed)
	localparam logic [15:0] ADDR_EXT_INDEX = 16'h4038;
	localparam logic [15:0] ADDR_EXT_DATA = 16'h403C;
	localparam logic [15:0] ADDR_INPUT_CTRL = 16'h4040;
	localparam logic [15:0] ADDR_RSVD_WORD = 16'h4044;
	localparam logic [15:0] ADDR_PIN_STATUS = 16'h4048;
	localparam logic [15:0] ADDR_EVENT_STATUS = 16'h404C;
	localparam logic [15:0] ADDR_EVENT_MASK = 16'h4050;
	// Printed offsets kept for reference of the layout
	localparam logic [15:0] OFS_INPUT_CTRL = 16'h4040;
	localparam logic [15:0] OFS_RSVD_WORD = 16'h4042;
	localparam logic [15:0] OFS_PIN_STATUS = 16'h4044;
	// Extended register indexes
	localparam logic [7:0] IDX_RX_FULL_THR = 8'h06;
	localparam logic [7:0] IDX_TX_LOW_THR = 8'h07;
	localparam logic [7:0] IDX_STRING_CTRL = 8'h08;
	localparam logic [7:0] IDX_MAX_CURRENT = 8'h09;
	localparam logic [7:0] IDX_TOGGLE_CTRL = 8'h0A;
	localparam logic [7:0] IDX_RSVD_BYTE = 8'h0B;
	localparam logic [7:0] IDX_TX_VALID_CTRL = 8'h0C;
	// Reset values
	localparam logic [5:0] RST_RX_FULL_THR = 6'h3C;
	localparam logic [5:0] RST_TX_LOW_THR = 6'h04;
	localparam logic [7:0] RST_MAX_CURRENT = 8'hFA;
	localparam logic [7:0] RST_INPUT_CTRL = 8'h0D;
	localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
	// Field positions
	localparam int BIT_RX_ENABLE = 6;
	localparam int BIT_BULK_MODE = 3;
	localparam int BIT_WAKE_N = 2;
	localparam int BIT_DETECT = 1;
	localparam int BIT_PULLUP = 0;
	localparam int BIT_TOG_EP4 = 7;
	localparam int BIT_TOG_EP3 = 6;
	localparam int BIT_TOG_EP2 = 5;
	localparam int BIT_TOG_EP1 = 4;
	// Event status bits
	localparam int EV_RX_FULL = 0;
	localparam int EV_TX_LOW = 1;
	localparam int EV_DETECT = 2;
	localparam int EV_WIDTH = 3;
	// Timing
	localparam longint CLK_HZ = 25000000;
	localparam longint DETECT_STEADY_MS = 500;
	localparam longint DETECT_CYCLES = (DETECT_STEADY_MS * CLK_HZ) / 1000;
	// Endpoint event from the USB engine, one-cycle pulses
	typedef struct packed {
		logic in_done_ep4;
		logic in_done_ep2;
		logic out_done_ep3;
		logic out_done_ep1;
	} ep_event_t;
	// Toggle values presented to the USB engine
	typedef struct packed {
		logic ep4_send;
		logic ep3_expect;
		logic ep2_send;
		logic ep1_expect;
	} ep_toggle_t;
endpackage

// ---- design/usb_function_ext_config.sv ----
// USB function configuration registers: indexed extended set, input control, pin status
// Operation
// R01: Data port reaches register chosen by index
// R02: Almost full when count above threshold
// R03: Almost empty below 6-bit threshold, reset 04h
// R04: String enable selects descriptors or zero indexes
// R05: Max current in 2 mA steps, reset FAh
// R06: Software keeps max current at most FAh
// R07: EP4/EP2 send toggle from bits 7/5
// R08: EP3/EP1 expect toggle from bits 6/4
// R09: Software waits 12 clocks before toggle readback
// R10: Software writes zero to reserved bits
// R11: Valid mode NAKs EP4 without valid flag
// R12: Bit 6 enables differential receiver
// R13: Bit 3 selects bulk, else isochronous
// R14: Writing 0 to bit 2 starts wake-up
// R15: Input control resets to 0Dh
// R16: Other indexed registers reset to zero (the RX full threshold resets to 3Ch here)
// R17: Detect status after 0.5 s steady
// R18: Bit 0 drives pull-up output
// R19: Toggles invert after each good transaction
//
// Implementation choice: the APB interface to the registers.
module usb_function_ext_config import usb_cfg_pkg::*; #(
	parameter longint DETECT_STEADY_CYCLES = DETECT_CYCLES,
	parameter int FIFO_CNT_W = 7
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic BUS_DETECT_INPUT,
	output logic BUS_PULLUP_OUTPUT,
	output logic DIFF_RECEIVER_ENABLE,
	output logic BULK_MODE,
	output logic REMOTE_WAKE_START,
	output logic STRING_ENABLE,
	output logic [7:0] MAX_BUS_CURRENT,
	input wire logic [FIFO_CNT_W-1:0] RX_FIFO_COUNT,
	input wire logic [FIFO_CNT_W-1:0] TX_FIFO_COUNT,
	output logic RX_ALMOST_FULL,
	output logic TX_ALMOST_EMPTY,
	input wire ep_event_t EP_EVENT,
	output ep_toggle_t EP_TOGGLE,
	input wire logic TX_ENDPOINT_VALID,
	output logic TX_EP4_NAK,
	output logic IRQ
);
	localparam int DCW = 25;

	logic [7:0] index_q, index_d;
	logic [5:0] rx_thr_q, rx_thr_d;
	logic [5:0] tx_thr_q, tx_thr_d;
	logic [7:0] string_q, string_d;
	logic [7:0] maxcur_q, maxcur_d;
	logic [7:0] toggle_q, toggle_d;
	logic [7:0] rsvd_q, rsvd_d;
	logic [7:0] txvalid_q, txvalid_d;
	logic [7:0] inctl_q, inctl_d;
	logic pullup_q, pullup_d;
	logic [EV_WIDTH-1:0] status_q, status_d;
	logic [EV_WIDTH-1:0] mask_q, mask_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic wake_q, wake_d;
	logic det_s1_q, det_s2_q;
	logic det_stable_q, det_stable_d;
	logic [DCW-1:0] det_cnt_q, det_cnt_d;
	logic rxf_q, rxf_d;
	logic txe_q, txe_d;
	logic nak_q, nak_d;
	logic irq_q, irq_d;

	logic setup;
	logic wr;
	logic rd;
	logic [7:0] ext_rdata;
	logic hit;

	function automatic logic [31:0] zext8(input logic [7:0] v);
		return {24'h000000, v};
	endfunction

	assign setup = PSEL && !PENABLE;
	assign wr = setup && PWRITE;
	assign rd = setup && !PWRITE;

	// Indexed read mux; unknown indexes read zero
	always_comb begin
		unique case (index_q) // [R01]
			IDX_RX_FULL_THR: ext_rdata = {2'b00, rx_thr_q};
			IDX_TX_LOW_THR: ext_rdata = {2'b00, tx_thr_q};
			IDX_STRING_CTRL: ext_rdata = string_q;
			IDX_MAX_CURRENT: ext_rdata = maxcur_q;
			IDX_TOGGLE_CTRL: ext_rdata = toggle_q;
			IDX_RSVD_BYTE: ext_rdata = rsvd_q;
			IDX_TX_VALID_CTRL: ext_rdata = txvalid_q;
			default: ext_rdata = 8'h00;
		endcase
	end

	always_comb begin
		unique case (PADDR)
			ADDR_EXT_INDEX, ADDR_EXT_DATA, ADDR_INPUT_CTRL, ADDR_RSVD_WORD,
			ADDR_PIN_STATUS, ADDR_EVENT_STATUS, ADDR_EVENT_MASK: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// Register file and APB slave; answer one cycle after setup
	always_comb begin
		index_d = index_q;
		rx_thr_d = rx_thr_q;
		tx_thr_d = tx_thr_q;
		string_d = string_q;
		maxcur_d = maxcur_q;
		toggle_d = toggle_q;
		rsvd_d = rsvd_q;
		txvalid_d = txvalid_q;
		inctl_d = inctl_q;
		pullup_d = pullup_q;
		mask_d = mask_q;
		prdata_d = 32'h00000000;
		pready_d = setup;
		pslverr_d = setup && !hit;
		wake_d = 1'b0;
		// Hardware toggle flips; a software write in the same cycle takes over
		toggle_d[BIT_TOG_EP4] = toggle_q[BIT_TOG_EP4] ^ EP_EVENT.in_done_ep4; // [R19]
		toggle_d[BIT_TOG_EP3] = toggle_q[BIT_TOG_EP3] ^ EP_EVENT.out_done_ep3; // [R19]
		toggle_d[BIT_TOG_EP2] = toggle_q[BIT_TOG_EP2] ^ EP_EVENT.in_done_ep2; // [R19]
		toggle_d[BIT_TOG_EP1] = toggle_q[BIT_TOG_EP1] ^ EP_EVENT.out_done_ep1; // [R19]
		if (wr) begin
			unique case (PADDR)
				ADDR_EXT_INDEX: index_d = PWDATA[7:0]; // [R01]
				ADDR_EXT_DATA: begin
					unique case (index_q) // [R01]
						IDX_RX_FULL_THR: rx_thr_d = PWDATA[5:0];
						IDX_TX_LOW_THR: tx_thr_d = PWDATA[5:0]; // [R03]
						IDX_STRING_CTRL: string_d = PWDATA[7:0];
						IDX_MAX_CURRENT: maxcur_d = PWDATA[7:0]; // [R05]
						IDX_TOGGLE_CTRL: toggle_d = PWDATA[7:0];
						IDX_RSVD_BYTE: rsvd_d = PWDATA[7:0];
						IDX_TX_VALID_CTRL: txvalid_d = PWDATA[7:0];
						default: ;
					endcase
				end
				ADDR_INPUT_CTRL: begin
					inctl_d = PWDATA[7:0];
					wake_d = !PWDATA[BIT_WAKE_N]; // [R14]
				end
				ADDR_PIN_STATUS: pullup_d = PWDATA[BIT_PULLUP]; // [R18]
				ADDR_EVENT_MASK: mask_d = PWDATA[EV_WIDTH-1:0];
				default: ;
			endcase
		end
		if (rd) begin
			unique case (PADDR)
				ADDR_EXT_INDEX: prdata_d = zext8(index_q);
				ADDR_EXT_DATA: prdata_d = zext8(ext_rdata);
				ADDR_INPUT_CTRL: prdata_d = zext8(inctl_q);
				ADDR_PIN_STATUS: prdata_d = {30'h0, det_stable_q, pullup_q}; // [R17]
				ADDR_EVENT_STATUS: prdata_d = {29'h0, status_q};
				ADDR_EVENT_MASK: prdata_d = {29'h0, mask_q};
				default: prdata_d = 32'h00000000;
			endcase
		end
	end

	// Pin synchroniser; the first stage feeds only the second
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			det_s1_q <= 1'b0;
			det_s2_q <= 1'b0;
		end else begin
			det_s1_q <= BUS_DETECT_INPUT;
			det_s2_q <= det_s1_q;
		end
	end

	// Debounce: level must hold for the full steady period before it shows
	always_comb begin
		det_stable_d = det_stable_q;
		det_cnt_d = det_cnt_q;
		if (det_s2_q == det_stable_q) begin
			det_cnt_d = '0;
		end else if (det_cnt_q >= DCW'(DETECT_STEADY_CYCLES - 1)) begin
			det_cnt_d = '0;
			det_stable_d = det_s2_q; // [R17]
		end else begin
			det_cnt_d = det_cnt_q + DCW'(1);
		end
	end

	// FIFO levels, endpoint NAK and interrupt
	always_comb begin
		rxf_d = RX_FIFO_COUNT > FIFO_CNT_W'(rx_thr_q); // [R02]
		txe_d = TX_FIFO_COUNT < FIFO_CNT_W'(tx_thr_q); // [R03]
		nak_d = txvalid_q[0] && !TX_ENDPOINT_VALID; // [R11]
		status_d = status_q;
		// A read clears; new events in the same cycle still set
		if (rd && PADDR == ADDR_EVENT_STATUS) begin
			status_d = '0;
		end
		if (rxf_d && !rxf_q) status_d[EV_RX_FULL] = 1'b1;
		if (txe_d && !txe_q) status_d[EV_TX_LOW] = 1'b1;
		if (det_stable_d != det_stable_q) status_d[EV_DETECT] = 1'b1;
		irq_d = |(status_d & mask_d);
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			index_q <= RST_ZERO_BYTE;
			rx_thr_q <= RST_RX_FULL_THR;
			tx_thr_q <= RST_TX_LOW_THR; // [R03]
			string_q <= RST_ZERO_BYTE;
			maxcur_q <= RST_MAX_CURRENT; // [R05]
			toggle_q <= RST_ZERO_BYTE; // [R16]
			rsvd_q <= RST_ZERO_BYTE; // [R16]
			txvalid_q <= RST_ZERO_BYTE; // [R16]
			inctl_q <= RST_INPUT_CTRL; // [R15]
			pullup_q <= 1'b0;
			status_q <= '0;
			mask_q <= '0;
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			wake_q <= 1'b0;
			det_stable_q <= 1'b0;
			det_cnt_q <= '0;
			rxf_q <= 1'b0;
			txe_q <= 1'b0;
			nak_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			index_q <= index_d;
			rx_thr_q <= rx_thr_d;
			tx_thr_q <= tx_thr_d;
			string_q <= string_d;
			maxcur_q <= maxcur_d;
			toggle_q <= toggle_d;
			rsvd_q <= rsvd_d;
			txvalid_q <= txvalid_d;
			inctl_q <= inctl_d;
			pullup_q <= pullup_d;
			status_q <= status_d;
			mask_q <= mask_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			wake_q <= wake_d;
			det_stable_q <= det_stable_d;
			det_cnt_q <= det_cnt_d;
			rxf_q <= rxf_d;
			txe_q <= txe_d;
			nak_q <= nak_d;
			irq_q <= irq_d;
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign BUS_PULLUP_OUTPUT = pullup_q; // [R18]
	assign DIFF_RECEIVER_ENABLE = inctl_q[BIT_RX_ENABLE]; // [R12]
	assign BULK_MODE = inctl_q[BIT_BULK_MODE]; // [R13]
	assign REMOTE_WAKE_START = wake_q; // [R14]
	assign STRING_ENABLE = string_q[0]; // [R04]
	assign MAX_BUS_CURRENT = maxcur_q; // [R05]
	assign EP_TOGGLE = {toggle_q[BIT_TOG_EP4], toggle_q[BIT_TOG_EP3],
		toggle_q[BIT_TOG_EP2], toggle_q[BIT_TOG_EP1]}; // [R07] [R08]
	assign RX_ALMOST_FULL = rxf_q;
	assign TX_ALMOST_EMPTY = txe_q;
	assign TX_EP4_NAK = nak_q; // [R11]
	assign IRQ = irq_q;
endmodule // usb_function_ext_config

// ---- dv/test_usb_function_ext_config.sv ----
// Self-checking bench for the USB function configuration block
module test_usb_function_ext_config import usb_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] i; logic [7:0] w; logic [7:0] e;} row_t;
	row_t rows[7] = '{'{8'h06, 8'h0A, 8'h0A}, '{8'h07, 8'h3F, 8'h3F}, '{8'h09, 8'h64, 8'h64},
		'{8'h0B, 8'h00, 8'h00}, '{8'h0C, 8'h01, 8'h01}, '{8'h20, 8'h55, 8'h00},
		'{8'h08, 8'h01, 8'h01}};
	logic REF_CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [15:0] PADDR = 16'h0000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA, rdat;
	logic PREADY, PSLVERR, err, BUS_DETECT_INPUT, BUS_PULLUP_OUTPUT, DIFF_RECEIVER_ENABLE;
	logic BULK_MODE, REMOTE_WAKE_START, STRING_ENABLE, RX_ALMOST_FULL, TX_ALMOST_EMPTY;
	logic TX_ENDPOINT_VALID, TX_EP4_NAK, IRQ;
	logic [7:0] MAX_BUS_CURRENT;
	logic [6:0] RX_FIFO_COUNT, TX_FIFO_COUNT;
	ep_event_t EP_EVENT;
	ep_toggle_t EP_TOGGLE;
	int bad_count = 0;
	int checked = 0;
	usb_function_ext_config #(.DETECT_STEADY_CYCLES(8)) i_dut (.*);
	usb_host_model i_host (.clk(REF_CLK), .ev(EP_EVENT), .valid(TX_ENDPOINT_VALID),
		.detect(BUS_DETECT_INPUT), .rx_cnt(RX_FIFO_COUNT), .tx_cnt(TX_FIFO_COUNT));
	always #20 REF_CLK = ~REF_CLK;
	task stop_test;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask
	task settle(input int n);
		repeat (n) @(posedge REF_CLK);
		@(negedge REF_CLK);
	endtask
	// Waits on the slave's ready, no fixed latency assumed
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		// Look at ready mid-cycle, where it is settled, and end the access at the next edge
		@(negedge REF_CLK);
		while (PREADY !== 1'b1) @(negedge REF_CLK);
		rdat = PRDATA;
		err = PSLVERR;
		@(posedge REF_CLK);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task ext(input logic w, input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, ADDR_EXT_INDEX, {24'h0, i});
		apb(w, ADDR_EXT_DATA, {24'h0, d});
	endtask
	initial begin
		repeat (12) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		foreach (rows[k]) begin
			ext(1'b1, rows[k].i, rows[k].w);
			ext(1'b0, rows[k].i, 8'h00);
			chk("ext", {24'h0, rows[k].e}, rdat);
		end
		chk("current", 32'h64, MAX_BUS_CURRENT);
		chk("string", 1, STRING_ENABLE);
		$display("rows end");
		i_host.levels(7'd11, 7'd63, 1'b0, 1'b0);
		settle(2);
		chk("full", 1, RX_ALMOST_FULL);
		chk("empty", 0, TX_ALMOST_EMPTY);
		i_host.levels(7'd10, 7'd62, 1'b0, 1'b0);
		settle(2);
		chk("full", 0, RX_ALMOST_FULL);
		chk("empty", 1, TX_ALMOST_EMPTY);
		chk("nak", 1, TX_EP4_NAK);
		i_host.levels(7'd64, 7'd64, 1'b1, 1'b0);
		settle(2);
		chk("full", 1, RX_ALMOST_FULL);
		chk("nak", 0, TX_EP4_NAK);
		$display("levels end");
		apb(1'b1, ADDR_INPUT_CTRL, 32'h48);
		chk("rxen", 1, DIFF_RECEIVER_ENABLE);
		apb(1'b1, ADDR_INPUT_CTRL, 32'h04);
		chk("rxen", 0, DIFF_RECEIVER_ENABLE);
		chk("bulk", 0, BULK_MODE);
		apb(1'b1, ADDR_PIN_STATUS, 32'h1);
		chk("pullup", 1, BUS_PULLUP_OUTPUT);
		i_host.levels(7'd64, 7'd64, 1'b1, 1'b1);
		settle(20);
		chk("irq masked", 0, IRQ);
		apb(1'b1, ADDR_EVENT_MASK, 32'h4);
		settle(1);
		chk("irq", 1, IRQ);
		apb(1'b0, ADDR_PIN_STATUS, 0);
		chk("pins", 32'h3, rdat);
		apb(1'b0, ADDR_EVENT_STATUS, 0);
		chk("events", 32'h7, rdat);
		settle(1);
		chk("irq", 0, IRQ);
		$display("pins end");
		ext(1'b1, IDX_TOGGLE_CTRL, 8'hA0);
		chk("toggles", 4'hA, EP_TOGGLE);
		i_host.pulse(4'hF);
		settle(1);
		chk("toggles", 4'h5, EP_TOGGLE);
		repeat (12) @(posedge REF_CLK);
		ext(1'b0, IDX_TOGGLE_CTRL, 8'h00);
		chk("toggles", 32'h50, rdat);
		apb(1'b0, 16'h4100, 0);
		chk("unmapped", 0, rdat);
		chk("slverr", 1, err);
		$display("toggle end");
		SYS_RST <= 1'b1;
		repeat (12) @(posedge REF_CLK);
		SYS_RST <= 1'b0;
		chk("bulk", 1, BULK_MODE);
		chk("current", 32'hFA, MAX_BUS_CURRENT);
		chk("toggles", 0, EP_TOGGLE);
		apb(1'b0, ADDR_INPUT_CTRL, 0);
		chk("input", 32'h0D, rdat);
		ext(1'b0, IDX_TX_LOW_THR, 8'h00);
		chk("tx thr", 32'h04, rdat);
		$display("reset end");
		stop_test;
	end
	initial begin
		repeat (5000) @(posedge REF_CLK);
		bad_count++;
		stop_test;
	end
endmodule // test_usb_function_ext_config

// ---- dv/usb_cfg_monitor.sv ----
// Port checker for the USB configuration block
module usb_cfg_monitor import usb_cfg_pkg::*; #(
	parameter int FIFO_CNT_W = 7
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic BUS_PULLUP_OUTPUT,
	input wire logic DIFF_RECEIVER_ENABLE,
	input wire logic BULK_MODE,
	input wire logic REMOTE_WAKE_START,
	input wire logic [7:0] MAX_BUS_CURRENT,
	input wire logic [FIFO_CNT_W-1:0] RX_FIFO_COUNT,
	input wire logic [FIFO_CNT_W-1:0] TX_FIFO_COUNT,
	input wire logic RX_ALMOST_FULL,
	input wire logic TX_ALMOST_EMPTY,
	input wire ep_event_t EP_EVENT,
	input wire ep_toggle_t EP_TOGGLE,
	input wire logic TX_ENDPOINT_VALID,
	input wire logic TX_EP4_NAK
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	logic setup;
	logic wr_ctl;
	logic wr_ext;
	assign setup = PSEL && !PENABLE;
	assign wr_ctl = setup && PWRITE && PADDR == ADDR_INPUT_CTRL;
	assign wr_ext = setup && PWRITE && PADDR == ADDR_EXT_DATA;
	// Wake request must be a strobe, a level would restart signalling
	sequence s_wake;
		REMOTE_WAKE_START ##1 !REMOTE_WAKE_START;
	endsequence
	AST_READY: assert property (setup |=> PREADY) else $error("ready late");
	AST_NO_READY: assert property (!setup |=> !PREADY) else $error("stray ready");
	AST_UNMAPPED: assert property (setup && PADDR[15:8] != 8'h40 |=> PSLVERR && PRDATA == 0)
		else $error("unmapped access");
	AST_RX_EN: assert property (wr_ctl |=> DIFF_RECEIVER_ENABLE == $past(PWDATA[6]))
		else $error("receiver enable");
	AST_BULK: assert property (wr_ctl |=> BULK_MODE == $past(PWDATA[3]))
		else $error("bulk mode");
	AST_WAKE: assert property (wr_ctl && !PWDATA[2] |=> s_wake) else $error("wake");
	AST_PULLUP: assert property (setup && PWRITE && PADDR == ADDR_PIN_STATUS |=>
		BUS_PULLUP_OUTPUT == $past(PWDATA[0])) else $error("pullup");
	AST_CUR_HOLD: assert property (!wr_ext |=> $stable(MAX_BUS_CURRENT))
		else $error("current changed");
	AST_TOGGLE: assert property (EP_EVENT.in_done_ep4 && !wr_ext |=>
		EP_TOGGLE.ep4_send != $past(EP_TOGGLE.ep4_send)) else $error("toggle");
	AST_NAK: assert property ($past(TX_ENDPOINT_VALID) |-> !TX_EP4_NAK) else $error("nak");
	AST_FULL: assert property (RX_FIFO_COUNT >= 64 |=> RX_ALMOST_FULL) else $error("full");
	AST_EMPTY: assert property (TX_FIFO_COUNT >= 64 |=> !TX_ALMOST_EMPTY) else $error("empty");
endmodule // usb_cfg_monitor

bind usb_function_ext_config usb_cfg_monitor #(.FIFO_CNT_W(FIFO_CNT_W)) i_mon (.*);

// ---- dv/usb_host_model.sv ----
// Far-side model: transaction events, FIFO levels, valid flag and detect pin
module usb_host_model import usb_cfg_pkg::*; (
	input wire logic clk,
	output ep_event_t ev = '0,
	output logic valid = 1'b0,
	output logic detect = 1'b0,
	output logic [6:0] rx_cnt = 7'h00,
	output logic [6:0] tx_cnt = 7'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// One strobe per completed transaction
	task pulse(input ep_event_t e);
		@(posedge clk) ev <= e;
		@(posedge clk) ev <= '0;
	endtask
	task levels(input logic [6:0] r, input logic [6:0] t, input logic v, input logic d);
		@(posedge clk);
		rx_cnt <= r;
		tx_cnt <= t;
		valid <= v;
		detect <= d;
	endtask
endmodule // usb_host_model
